/* File: tb/dual_gain_spi_control_test.sv */
// Self-checking bench for the serial gain control block
`timescale 1ns/1ps

module dual_gain_spi_control_test;
    import gain_spi_pkg::*;

    // ==========
    // Design connections
    logic        core_clk;
    logic        srst;
    logic        sclk;
    logic        cs_n;
    logic        serial_in;
    logic        serial_out;
    logic        serial_out_oe;
    logic        pa1, pa2, pb1, pb2;
    gain_code_t  chan_a_gain;
    gain_code_t  chan_b_gain;
    // Reference model state
    int          regs [8];
    int          cha, chb;
    int          fail_count, cmp_count;
    logic [31:0] seed;

    dual_gain_spi_control i_dual_gain_spi_control (
        .core_clk(core_clk), .srst(srst), .sclk(sclk), .cs_n(cs_n),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .chan_a_power_off_first(pa1), .chan_a_power_off_second(pa2),
        .chan_b_power_off_first(pb1), .chan_b_power_off_second(pb2),
        .chan_a_gain(chan_a_gain), .chan_b_gain(chan_b_gain));

    spi_host_model i_spi_host_model (
        .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe));

    // Core clock, 5 ns
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ==========
    // Helpers
    function automatic logic [31:0] xrand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Writable bits per address
    function automatic int wmask(input int a);
        case (a)
            2: return 8'h3c;
            3, 4: return 8'h7f;
            5: return 8'h07;
            6: return 8'hff;
            default: return 8'h00;
        endcase
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Power and gain outputs against the model
    task automatic check_outs();
        check({2'b00, pa1, pb1, pa2, pb2, 2'b00}, regs[2][7:0]);
        check({1'b0, chan_a_gain}, cha[7:0]);
        check({1'b0, chan_b_gain}, chb[7:0]);
        check({6'h00, serial_out_oe, serial_out}, 8'h00);
    endtask

    task automatic wr(input int a, input logic [7:0] d);
        logic [7:0] v;
        i_spi_host_model.xfer({5'h00, a[2:0], d}, 16, v);
        if (wmask(a) != 0) begin
            regs[a] = d & wmask(a);
        end
        if (regs[5][1]) begin
            cha = regs[3];
        end
        if (regs[5][0]) begin
            chb = regs[5][2] ? regs[3] : regs[4];
        end
        check_outs();
    endtask

    // Read with random data field, which must be ignored
    task automatic rd_chk(input int a);
        logic [7:0]  v;
        logic [31:0] r;
        r = xrand();
        i_spi_host_model.xfer({5'h10, a[2:0], r[7:0]}, 16, v);
        check(v, regs[a][7:0]);
        check_outs();
    endtask

    // Aborted write of n clocks
    task automatic short_wr(input int a, input int n);
        logic [7:0]  v;
        logic [31:0] r;
        r = xrand();
        i_spi_host_model.xfer({5'h00, a[2:0], r[7:0]}, n, v);
        check_outs();
    endtask

    task automatic test_done();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        #400000;
        fail_count++;
        test_done();
    end

    // ==========
    // Main sequence
    initial begin
        logic [31:0] r;
        seed = 32'h7edaa945;
        fail_count = 0;
        cmp_count = 0;
        regs = '{8'h0a, 8'h5c, 8'h00, 8'h50, 8'h50, 8'h03, 8'h00, 8'h00};
        cha = 8'h50;
        chb = 8'h50;
        srst = 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        // Reset values of every address
        for (int a = 0; a < 8; a++) rd_chk(a);
        // Random writes everywhere, then read back
        repeat (2) begin
            for (int a = 0; a < 8; a++) begin
                r = xrand();
                wr(a, r[7:0]);
            end
        end
        for (int a = 0; a < 8; a++) rd_chk(a);
        // Every routing mode with fresh gains
        for (int m = 0; m < 8; m++) begin
            wr(5, m[7:0]);
            r = xrand();
            wr(3, r[7:0]);
            r = xrand();
            wr(4, r[7:0]);
            wr(2, r[15:8]);
        end
        // Aborted frames change nothing
        short_wr(3, 15);
        short_wr(4, 8);
        short_wr(2, 1);
        for (int a = 2; a < 7; a++) rd_chk(a);
        test_done();
    end
endmodule // dual_gain_spi_control_test

/* File: tb/spi_host_model.sv */
// Serial host model that sends frames to the gain control block
`timescale 1ns/1ps

module spi_host_model (
    // Serial link to the device
    output logic      sclk,
    output logic      cs_n,
    output logic      serial_in,
    input  wire logic serial_out,
    input  wire logic serial_out_oe
);
    // Bias resistor pulls the undriven line low
    wire logic sdo_line = serial_out_oe ? serial_out : 1'b0;

    // Idle: clock low, deselected
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        serial_in = 1'b0;
    end

    // ==========
    // One frame, MSB first, nbits clocks (fewer than 16 aborts it)
    task automatic xfer(input logic [15:0] frame, input int nbits, output logic [7:0] rd);
        rd = 8'h00;
        #37;  // Phase unrelated to the core clock
        cs_n = 1'b0;
        for (int i = 15; i > 15 - nbits; i--) begin
            serial_in = frame[i];
            #62.5;
            sclk = 1'b1;
            if (i < 8) begin
                rd = {rd[6:0], sdo_line};
            end
            #62.5;
            sclk = 1'b0;
        end
        serial_in = ~serial_in;  // Released data no longer valid
        #62.5;
        cs_n = 1'b1;
        #150;  // Gap lets the commit land
    endtask
endmodule // spi_host_model

/* File: verilog/dual_gain_spi_control.sv */
// Serial control registers and gain routing for a dual programmable-gain amplifier
//
// How it works
// R1 - Channel A power bits 5,3; 1 is off
// R2 - Channel B power bits 4,2; others reserved
// R3 - Gain code bits 6:0, gain 26-code/4
// R4 - Sync set: register 3 drives both channels
// R5 - Sync clear: registers 3,4 drive independently
// R6 - Load A clear: channel A gain holds
// R7 - Load A set: channel A follows register 3
// R8 - Load B gates register 4 likewise
// R9 - First frame bit: 1 read, 0 write
// R10 - Host sends reserved frame bits as zero
// R11 - Address field selects accessed register
// R12 - Write commits at select release; reads discard
// R13 - Sample on rising, drive on falling
// R14 - Short frame: no capture, no write
// R15 - Read data on second eight falls
// R16 - Registers 0,1 read only; 2-6 writable
// R17 - Reserved bits always read as zero
`timescale 1ns/1ps
`include "gain_spi_map.svh"

module dual_gain_spi_control
    import gain_spi_pkg::*;
(
    // Core clock and reset
    input  wire logic       core_clk,
    input  wire logic       srst,
    // Serial link from host
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       serial_in,
    output logic            serial_out,
    output logic            serial_out_oe,
    // Channel power controls, 1 = stage off
    output logic            chan_a_power_off_first,
    output logic            chan_a_power_off_second,
    output logic            chan_b_power_off_first,
    output logic            chan_b_power_off_second,
    // Applied gain codes
    output gain_code_t      chan_a_gain,
    output gain_code_t      chan_b_gain
);

    // ==========================================================
    // Link domain: frame capture on sclk

    bit_count_t  bit_cnt_q;    // Rising edges seen this frame
    frame_t      shift_q;      // Received frame bits
    logic        frame_full_q; // Sixteen clocks received
    reg_byte_t   rd_shift_q;   // Read data on its way out

    // Count rising edges; chip select high restarts the frame
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            bit_cnt_q <= 5'h00;
        end else if (bit_cnt_q != `FRAME_BITS) begin
            // Saturate at sixteen, extra clocks are ignored
            bit_cnt_q <= bit_cnt_q + 5'h01; // R14
        end
    end

    // Sample the data pin on the rising edge. No reset here: the frame
    // must outlive chip select release until the core has committed it.
    always_ff @(posedge sclk) begin
        if (!cs_n && bit_cnt_q != `FRAME_BITS) begin
            shift_q <= {shift_q[14:0], serial_in}; // R13
        end
    end

    // Full frame flag, cleared only by chip select release
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            frame_full_q <= 1'b0;
        end else if (bit_cnt_q == `FRAME_BITS - 5'h01) begin
            frame_full_q <= 1'b1; // R14
        end
    end

    // ==========================================================
    // Register read mux

    reg_byte_t  power_q;    // Power control register
    reg_byte_t  gain_a_q;   // Gain code register A
    reg_byte_t  gain_b_q;   // Gain code register B
    reg_byte_t  routing_q;  // Gain routing register
    reg_byte_t  spare_q;    // Spare writable register

    // Value seen by a read of one address
    function automatic reg_byte_t reg_read(input reg_addr_t addr);
        case (addr) // R11
            `ADDR_REV_ID:  reg_read = `REV_ID_VALUE;  // Arbitrary value
            `ADDR_PART_ID: reg_read = `PART_ID_VALUE; // Arbitrary value
            `ADDR_POWER:   reg_read = power_q;
            `ADDR_GAIN_A:  reg_read = gain_a_q;
            `ADDR_GAIN_B:  reg_read = gain_b_q;
            `ADDR_ROUTING: reg_read = routing_q;
            `ADDR_SPARE:   reg_read = spare_q;
            default:       reg_read = 8'h00;
        endcase
    endfunction

    // Read data changes on falling edges. Registers only change after
    // chip select release, so they stand still while a frame runs.
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            rd_shift_q <= 8'h00;
        end else if (bit_cnt_q == `HEAD_BITS) begin
            // Header done: load the addressed register on a read
            if (shift_q[7]) begin // R9
                rd_shift_q <= reg_read(shift_q[2:0]); // R15
            end else begin
                rd_shift_q <= 8'h00;
            end
        end else if (bit_cnt_q > `HEAD_BITS) begin
            // Next bit, most significant first
            rd_shift_q <= {rd_shift_q[6:0], 1'b0}; // R13
        end
    end

    // Output pin driven only while selected
    assign serial_out    = rd_shift_q[7];
    assign serial_out_oe = ~cs_n; // R15

    // ==========================================================
    // Core domain: synchronisers

    logic  cs_s1_q;     // Select, first stage
    logic  cs_s2_q;     // Select, second stage
    logic  cs_s3_q;     // Select, edge reference
    logic  full_s1_q;   // Full flag, first stage
    logic  full_s2_q;   // Full flag, second stage

    // Two flops for the full flag, three for select including the edge reference
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cs_s1_q   <= 1'b1;
            cs_s2_q   <= 1'b1;
            cs_s3_q   <= 1'b1;
            full_s1_q <= 1'b0;
            full_s2_q <= 1'b0;
        end else begin
            cs_s1_q   <= cs_n;
            cs_s2_q   <= cs_s1_q;
            cs_s3_q   <= cs_s2_q;
            full_s1_q <= frame_full_q;
            full_s2_q <= full_s1_q;
        end
    end

    // ==========================================================
    // Commit control

    logic       pending_q;  // Complete frame awaits release
    logic       cs_rise;    // Chip select release seen
    logic       commit_q;   // One-cycle commit pulse
    logic       wr_en;      // Register write this cycle
    frame_t     frame;      // Frame held since the last clock
    reg_addr_t  wr_addr;    // Addressed register
    reg_byte_t  wr_data;    // Data field

    assign cs_rise = cs_s2_q & ~cs_s3_q;

    // A frame is pending once sixteen clocks have arrived
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pending_q <= 1'b0;
        end else if (cs_rise) begin
            pending_q <= 1'b0;
        end else if (full_s2_q && !cs_s2_q) begin
            // Only while selected: a late full flag cannot re-arm a commit
            pending_q <= 1'b1; // R14
        end
    end

    // Commit on release, only after a complete frame
    always_ff @(posedge core_clk) begin
        if (srst) begin
            commit_q <= 1'b0;
        end else begin
            commit_q <= cs_rise & pending_q; // R12 R14
        end
    end

    // Frame register is quiet once the link clock has stopped
    assign frame   = shift_q;
    assign wr_addr = frame[`FRAME_ADDR_MSB:`FRAME_ADDR_LSB]; // R11
    assign wr_data = frame[7:0];
    // Writes only: read frames drop their data field
    assign wr_en   = commit_q & ~frame[`FRAME_RW_BIT]; // R9 R12

    // ==========================================================
    // Register file

    // Power register, reserved bits forced to zero
    always_ff @(posedge core_clk) begin
        if (srst) begin
            power_q <= `POWER_RESET;
        end else if (wr_en && wr_addr == `ADDR_POWER) begin
            power_q <= wr_data & `POWER_WR_MASK; // R2 R16 R17
        end
    end

    // Gain code registers, bit 7 reserved
    always_ff @(posedge core_clk) begin
        if (srst) begin
            gain_a_q <= `GAIN_RESET;
            gain_b_q <= `GAIN_RESET;
        end else if (wr_en) begin
            if (wr_addr == `ADDR_GAIN_A) begin
                gain_a_q <= wr_data & `GAIN_WR_MASK; // R3 R17
            end
            if (wr_addr == `ADDR_GAIN_B) begin
                gain_b_q <= wr_data & `GAIN_WR_MASK; // R3 R17
            end
        end
    end

    // Routing and spare registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            routing_q <= `ROUTING_RESET;
            spare_q   <= `SPARE_RESET;
        end else if (wr_en) begin
            if (wr_addr == `ADDR_ROUTING) begin
                routing_q <= wr_data & `ROUTE_WR_MASK; // R17
            end
            if (wr_addr == `ADDR_SPARE) begin
                spare_q <= wr_data; // R16
            end
        end
    end

    // ==========================================================
    // Power outputs

    assign chan_a_power_off_first  = power_q[`POWER_A_FIRST_BIT];  // R1
    assign chan_a_power_off_second = power_q[`POWER_A_SECOND_BIT]; // R1
    assign chan_b_power_off_first  = power_q[`POWER_B_FIRST_BIT];  // R2
    assign chan_b_power_off_second = power_q[`POWER_B_SECOND_BIT]; // R2

    // ==========================================================
    // Gain routing

    gain_code_t  chan_a_gain_q;  // Gain applied to channel A
    gain_code_t  chan_b_gain_q;  // Gain applied to channel B
    logic        sync_en;        // Register 3 drives both
    logic        load_a;         // Transfer enable, channel A
    logic        load_b;         // Transfer enable, channel B

    assign sync_en = routing_q[`ROUTE_SYNC_BIT];
    assign load_a  = routing_q[`ROUTE_LOAD_A_BIT];
    assign load_b  = routing_q[`ROUTE_LOAD_B_BIT];

    // Channel A follows register 3 while its load bit is set
    always_ff @(posedge core_clk) begin
        if (srst) begin
            chan_a_gain_q <= gain_code_t'(`GAIN_RESET);
        end else if (load_a) begin
            chan_a_gain_q <= gain_a_q[6:0]; // R7
        end else begin
            // Load clear: applied gain holds whatever register 3 does
            chan_a_gain_q <= chan_a_gain_q; // R6
        end
    end

    // Channel B takes register 3 in sync mode, else register 4
    always_ff @(posedge core_clk) begin
        if (srst) begin
            chan_b_gain_q <= gain_code_t'(`GAIN_RESET);
        end else if (load_b) begin
            if (sync_en) begin
                chan_b_gain_q <= gain_a_q[6:0]; // R4
            end else begin
                chan_b_gain_q <= gain_b_q[6:0]; // R5 R8
            end
        end
    end

    assign chan_a_gain = chan_a_gain_q;
    assign chan_b_gain = chan_b_gain_q;

    // ==========================================================
    // Assertions

    power_reserved_a: assert property (@(posedge core_clk) disable iff (srst) // R2
        power_q[7:6] == 2'b00 && power_q[1:0] == 2'b00)
        else $error("power reserved bits set");

    gain_reserved_a: assert property (@(posedge core_clk) disable iff (srst) // R3
        !gain_a_q[7] && !gain_b_q[7] && routing_q[7:3] == 5'h00)
        else $error("gain or routing reserved bit set");

    sync_route_a: assert property (@(posedge core_clk) disable iff (srst) // R4
        (sync_en && load_b) [*2] |-> chan_b_gain_q == $past(gain_a_q[6:0]))
        else $error("sync mode did not copy register 3 to channel B");

    indep_route_a: assert property (@(posedge core_clk) disable iff (srst) // R5
        (!sync_en && load_b) [*2] |-> chan_b_gain_q == $past(gain_b_q[6:0]))
        else $error("channel B not driven by register 4");

    hold_gain_a: assert property (@(posedge core_clk) disable iff (srst) // R6
        !load_a |=> $stable(chan_a_gain_q))
        else $error("channel A gain moved with load clear");

    load_gain_a: assert property (@(posedge core_clk) disable iff (srst) // R7
        load_a |=> chan_a_gain_q == $past(gain_a_q[6:0]))
        else $error("channel A gain did not follow register 3");

    short_frame_a: assert property (@(posedge core_clk) disable iff (srst) // R14
        (cs_rise && !pending_q) |=> !commit_q)
        else $error("commit after a short frame");

    commit_cause_a: assert property (@(posedge core_clk) disable iff (srst) // R12
        commit_q |-> $past(cs_rise) && $past(pending_q))
        else $error("commit without select release");

    read_only_a: assert property (@(posedge core_clk) disable iff (srst) // R16
        (wr_en && wr_addr < `ADDR_POWER) |=> $stable(power_q) && $stable(routing_q))
        else $error("read-only address changed a register");

    read_frame_a: assert property (@(posedge core_clk) disable iff (srst) // R9
        (commit_q && frame[`FRAME_RW_BIT]) |=>
            $stable(power_q) && $stable(gain_a_q) && $stable(gain_b_q))
        else $error("read frame wrote a register");

endmodule // dual_gain_spi_control

/* File: verilog/gain_spi_map.svh */
// Register offsets, field positions, reset values and frame layout constants
`ifndef GAIN_SPI_MAP_SVH
`define GAIN_SPI_MAP_SVH

// ==========================================================
// Register offsets (frame address field values)
`define ADDR_REV_ID       3'h0
`define ADDR_PART_ID      3'h1
`define ADDR_POWER        3'h2
`define ADDR_GAIN_A       3'h3
`define ADDR_GAIN_B       3'h4
`define ADDR_ROUTING      3'h5
`define ADDR_SPARE        3'h6

// ==========================================================
// Power register fields (1 = stage off)
`define POWER_A_FIRST_BIT  5
`define POWER_B_FIRST_BIT  4
`define POWER_A_SECOND_BIT 3
`define POWER_B_SECOND_BIT 2
`define POWER_WR_MASK      8'h3c

// ==========================================================
// Gain and routing fields
`define GAIN_WR_MASK       8'h7f
`define ROUTE_SYNC_BIT     2
`define ROUTE_LOAD_A_BIT   1
`define ROUTE_LOAD_B_BIT   0
`define ROUTE_WR_MASK      8'h07

// ==========================================================
// Reset values
`define POWER_RESET        8'h00
`define GAIN_RESET         8'h50
`define ROUTING_RESET      8'h03
`define SPARE_RESET        8'h00
`define REV_ID_VALUE       8'h0a
`define PART_ID_VALUE      8'h5c

// ==========================================================
// Serial frame layout
`define FRAME_BITS         5'd16
`define FRAME_RW_BIT       15
`define FRAME_ADDR_MSB     10
`define FRAME_ADDR_LSB     8
`define HEAD_BITS          5'd8

`endif

/* File: verilog/gain_spi_pkg.sv */
// Types shared by the serial gain control block
package gain_spi_pkg;
    typedef logic [7:0]  reg_byte_t;   // One register
    typedef logic [2:0]  reg_addr_t;   // Register address
    typedef logic [6:0]  gain_code_t;  // Gain code, 0.25 dB steps
    typedef logic [15:0] frame_t;      // One serial frame
    typedef logic [4:0]  bit_count_t;  // Clock count within a frame
endpackage
